/* File: ssd_regs.svh */
// Register offsets, field positions, reset values and timing counts of the diagnostic block.
// Assumes a 125 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH
`define SSD_CTRL_OFS     8'h00
`define SSD_STAT_OFS     8'h04
`define SSD_REQ_OFS      8'h08
`define SSD_CTRL_SER_BIT 0
`define SSD_CTRL_FRS_BIT 1
`define SSD_CTRL_RST     32'h00000000
`define SSD_REQ_FRS_BIT  7
`define SSD_CLK_MHZ      125
`define SSD_TICK_MS      250
`define SSD_TICK_CYC     (`SSD_TICK_MS * 1000 * `SSD_CLK_MHZ)
`define SSD_WARN_MIN     30
`define SSD_WARN_TICKS   (`SSD_WARN_MIN * 60 * 1000 / `SSD_TICK_MS)
`define SSD_PAUSE_TICKS  4
`define SSD_RESP_OKAY    2'b00
`define SSD_RESP_SLVERR  2'b10
`endif

/* File: ssd_pkg.sv */
// Types shared by the diagnostic block: sensed conditions, indicator set and fault states.
// Assumes the including design also includes ssd_regs.svh for numeric constants.
`default_nettype none
package ssd_pkg;
	typedef struct packed {
		logic supply_ok;
		logic ready;
		logic present;
		logic limit;
		logic safety_in_a;
		logic safety_in_b;
		logic flt_out_a;
		logic flt_out_b;
		logic cross_short;
		logic overtemp;
		logic act_err;
		logic internal;
		logic comm_err;
	} ssd_sense_t;
	typedef struct packed {
		logic green;
		logic red;
		logic yellow;
		logic diag;
		logic safety_out_a;
		logic safety_out_b;
	} ssd_ind_t;
	typedef enum logic [1:0] {
		ST_NORMAL,
		ST_WARN,
		ST_FAIL,
		ST_INTERNAL
	} ssd_state_t;
endpackage : ssd_pkg
`default_nettype wire

/* File: ssd_diag_status.sv */
// Indicator, diagnostic output, serial status bytes and failure-warning logic of a safety sensor.
// Assumes sensed conditions arrive asynchronously and the request byte comes from same-clock logic.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ssd_regs.svh"
module ssd_diag_status #(
	parameter int unsigned TICK_CYCLES = `SSD_TICK_CYC,
	parameter int unsigned WARN_TICKS  = `SSD_WARN_TICKS
) (
	// Clock and reset.
	input  wire logic              CLK,
	input  wire logic              ARST_N,
	// Sensed conditions from the front end.
	input  wire ssd_pkg::ssd_sense_t SENSE,
	// Request byte from the serial link framer.
	input  wire logic [7:0]        REQ_BYTE,
	input  wire logic              REQ_STB,
	// Indicators and outputs.
	output var  ssd_pkg::ssd_ind_t IND,
	output var  logic [7:0]        RESP_BYTE,
	output var  logic [7:0]        DIAG_BYTE,
	// AXI4-Lite slave.
	input  wire logic [7:0]        S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output var  logic              S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output var  logic              S_AXI_WREADY,
	output var  logic [1:0]        S_AXI_BRESP,
	output var  logic              S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [7:0]        S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output var  logic              S_AXI_ARREADY,
	output var  logic [31:0]       S_AXI_RDATA,
	output var  logic [1:0]        S_AXI_RRESP,
	output var  logic              S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY
);
	import ssd_pkg::*;

	// Flash-code number of the highest-priority failure cause, zero if none.
	function automatic logic [2:0] cause_code(input ssd_sense_t s);
		if (s.flt_out_a) begin
			cause_code = 3'h1;
		end else if (s.flt_out_b) begin
			cause_code = 3'h2;
		end else if (s.cross_short) begin
			cause_code = 3'h3;
		end else if (s.overtemp) begin
			cause_code = 3'h4;
		end else if (s.act_err) begin
			cause_code = 3'h5;
		end else begin
			cause_code = 3'h0;
		end
	endfunction : cause_code

	// Merge a write into a register word under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] st);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				merge[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////////////////
	// Synchroniser for the sensed conditions.
	ssd_sense_t sync1_q;
	ssd_sense_t s;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sync1_q <= '0;
			s       <= '0;
		end else begin
			sync1_q <= SENSE;
			s       <= sync1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Time base and flash sequencer.
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic        tick;
	logic        blink_q, blink_d;
	logic [3:0]  pos_q, pos_d;
	logic [2:0]  code_q, code_d;
	logic [15:0] warn_cnt_q, warn_cnt_d;
	ssd_state_t  st_q, st_d;
	logic        frs;
	logic        fault_any;
	logic [2:0]  code_now;

	assign tick      = (tick_cnt_q == TICK_CYCLES - 1);
	assign code_now  = cause_code(s);
	assign fault_any = s.flt_out_a | s.flt_out_b | s.cross_short | s.overtemp;

	always_comb begin
		tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
		blink_d    = tick ? ~blink_q : blink_q;
		pos_d      = pos_q;
		if (tick) begin
			// Group of code pulses, then a longer dark pause, repeating.
			if (pos_q >= {code_q, 1'b0} + 4'(`SSD_PAUSE_TICKS) - 4'h1) begin
				pos_d = 4'h0;
			end else begin
				pos_d = pos_q + 4'h1;
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tick_cnt_q <= 32'h0;
			blink_q    <= 1'b0;
			pos_q      <= 4'h0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			blink_q    <= blink_d;
			pos_q      <= pos_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Fault state machine with failure-warning delay.
	always_comb begin
		st_d       = st_q;
		code_d     = code_q;
		warn_cnt_d = warn_cnt_q;
		case (st_q)
			ST_NORMAL: begin
				warn_cnt_d = 16'h0;
				if (s.internal) begin
					st_d = ST_INTERNAL;
				end else if (s.act_err) begin
					st_d   = ST_FAIL;
					code_d = code_now;
				end else if (fault_any) begin
					st_d   = ST_WARN;
					code_d = code_now;
				end
			end
			ST_WARN: begin
				if (tick) begin
					warn_cnt_d = warn_cnt_q + 16'h1;
				end
				if (code_now != 3'h0) begin
					code_d = code_now;
				end
				if (s.internal) begin
					st_d = ST_INTERNAL;
				end else if (s.act_err || warn_cnt_q >= 16'(WARN_TICKS)) begin
					st_d = ST_FAIL;
				end else if (!fault_any) begin
					st_d = ST_NORMAL;
				end
			end
			ST_FAIL: begin
				if (s.internal) begin
					st_d = ST_INTERNAL;
				end else if (frs && code_now == 3'h0) begin
					st_d = ST_NORMAL;
				end
			end
			default: begin
				if (frs && !s.internal && code_now == 3'h0) begin
					st_d = ST_NORMAL;
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q       <= ST_NORMAL;
			code_q     <= 3'h0;
			warn_cnt_q <= 16'h0;
		end else begin
			st_q       <= st_d;
			code_q     <= code_d;
			warn_cnt_q <= warn_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Indicators, diagnostic line and serial bytes.
	logic [31:0] ctrl_q, ctrl_d;
	logic [7:0]  req_q, req_d;
	logic        ser;
	ssd_ind_t    ind_d;
	logic [7:0]  resp_d, diag_d;
	logic        outs_on;
	logic        red_flash;

	assign ser       = ctrl_q[`SSD_CTRL_SER_BIT];
	assign red_flash = (pos_q < {code_q, 1'b0}) && !pos_q[0];
	// Safety outputs need actuator, energised inputs and no latched failure.
	assign outs_on   = s.present && s.safety_in_a && s.safety_in_b &&
	                   (st_q == ST_NORMAL || st_q == ST_WARN);

	always_comb begin
		ind_d.green        = s.supply_ok && s.ready && st_q == ST_NORMAL && !fault_any &&
		                     !s.act_err && !s.internal;
		ind_d.yellow       = s.present && (!s.limit || blink_q);
		case (st_q)
			ST_WARN, ST_FAIL: ind_d.red = red_flash;
			ST_INTERNAL:      ind_d.red = 1'b1;
			default:          ind_d.red = 1'b0;
		endcase
		// Diagnostic low on any fault; pulses in limit area; unused in serial variant.
		ind_d.diag         = !ser && outs_on && st_q == ST_NORMAL && !fault_any &&
		                     !s.act_err && !s.internal && (!s.limit || blink_q);
		ind_d.safety_out_a = outs_on;
		ind_d.safety_out_b = outs_on;
		resp_d = {st_q == ST_FAIL || st_q == ST_INTERNAL, st_q == ST_WARN,
		          s.present && s.limit, s.safety_in_a && s.safety_in_b, 2'b00,
		          s.present && !s.act_err, outs_on};
		diag_d = {1'b0, st_q == ST_WARN && s.comm_err, s.internal,
		          st_q == ST_FAIL && s.act_err, s.overtemp, s.cross_short,
		          s.flt_out_b, s.flt_out_a};
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			IND       <= '0;
			RESP_BYTE <= 8'h00;
			DIAG_BYTE <= 8'h00;
		end else begin
			IND       <= ind_d;
			RESP_BYTE <= resp_d;
			DIAG_BYTE <= diag_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite register slave.
	logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0]  awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        bvalid_d, rvalid_d, arready_d;
	logic [1:0]  bresp_d, rresp_d;
	logic [31:0] rdata_d;
	logic        do_wr, frs_sw;

	assign do_wr  = aw_full_q && w_full_q && !S_AXI_BVALID;
	assign frs_sw = do_wr && awaddr_q == `SSD_CTRL_OFS && wstrb_q[0] &&
	                wdata_q[`SSD_CTRL_FRS_BIT];
	assign frs    = frs_sw || (REQ_STB && REQ_BYTE[`SSD_REQ_FRS_BIT]);

	always_comb begin
		aw_full_d = aw_full_q;
		awaddr_d  = awaddr_q;
		w_full_d  = w_full_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = S_AXI_BVALID && !S_AXI_BREADY;
		bresp_d   = S_AXI_BRESP;
		ctrl_d    = ctrl_q;
		req_d     = REQ_STB ? REQ_BYTE : req_q;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_full_d = 1'b1;
			awaddr_d  = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_full_d = 1'b1;
			wdata_d  = S_AXI_WDATA;
			wstrb_d  = S_AXI_WSTRB;
		end
		if (do_wr) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = `SSD_RESP_OKAY;
			if (awaddr_q == `SSD_CTRL_OFS) begin
				ctrl_d = merge(ctrl_q, wdata_q, wstrb_q) & 32'h00000001;
			end else if (awaddr_q == `SSD_REQ_OFS) begin
				if (wstrb_q[0]) begin
					req_d = wdata_q[7:0];
				end
			end else if (awaddr_q != `SSD_STAT_OFS) begin
				bresp_d = `SSD_RESP_SLVERR;
			end
		end
		rvalid_d  = S_AXI_RVALID && !S_AXI_RREADY;
		rdata_d   = S_AXI_RDATA;
		rresp_d   = S_AXI_RRESP;
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rvalid_d = 1'b1;
			rresp_d  = `SSD_RESP_OKAY;
			if (S_AXI_ARADDR == `SSD_CTRL_OFS) begin
				rdata_d = ctrl_q;
			end else if (S_AXI_ARADDR == `SSD_STAT_OFS) begin
				rdata_d = {14'h0000, st_q, DIAG_BYTE, RESP_BYTE};
			end else if (S_AXI_ARADDR == `SSD_REQ_OFS) begin
				rdata_d = {24'h000000, req_q};
			end else begin
				rdata_d = 32'h00000000;
				rresp_d = `SSD_RESP_SLVERR;
			end
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			ctrl_q        <= `SSD_CTRL_RST;
			req_q         <= 8'h00;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= 2'b00;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h00000000;
			S_AXI_RRESP   <= 2'b00;
		end else begin
			aw_full_q     <= aw_full_d;
			w_full_q      <= w_full_d;
			awaddr_q      <= awaddr_d;
			wdata_q       <= wdata_d;
			wstrb_q       <= wstrb_d;
			ctrl_q        <= ctrl_d;
			req_q         <= req_d;
			S_AXI_AWREADY <= !aw_full_d && !(S_AXI_AWVALID && S_AXI_AWREADY);
			S_AXI_WREADY  <= !w_full_d && !(S_AXI_WVALID && S_AXI_WREADY);
			S_AXI_BVALID  <= bvalid_d;
			S_AXI_BRESP   <= bresp_d;
			S_AXI_ARREADY <= arready_d && !(S_AXI_ARVALID && S_AXI_ARREADY);
			S_AXI_RVALID  <= rvalid_d;
			S_AXI_RDATA   <= rdata_d;
			S_AXI_RRESP   <= rresp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Checks.
	a_green_fault: assert property (@(posedge CLK) disable iff (!ARST_N)
		(st_q != ST_NORMAL) |=> !IND.green) else $error("green lit during fault");
	a_yellow_steady: assert property (@(posedge CLK) disable iff (!ARST_N)
		(s.present && !s.limit) |=> IND.yellow) else $error("yellow not steady");
	a_red_internal: assert property (@(posedge CLK) disable iff (!ARST_N)
		(st_q == ST_INTERNAL) |=> IND.red) else $error("red not steady");
	a_diag_fault: assert property (@(posedge CLK) disable iff (!ARST_N)
		fault_any |=> !IND.diag) else $error("diag high with fault");
	a_warn_outs: assert property (@(posedge CLK) disable iff (!ARST_N)
		(st_q == ST_WARN && outs_on) |=> (IND.safety_out_a && IND.safety_out_b && !IND.diag))
		else $error("warning outputs wrong");
	a_warn_expire: assert property (@(posedge CLK) disable iff (!ARST_N)
		(st_q == ST_WARN && warn_cnt_q >= 16'(WARN_TICKS)) |=> (st_q != ST_WARN && st_q != ST_NORMAL)
		##1 !IND.safety_out_a) else $error("warning did not expire");
	a_idle_outs: assert property (@(posedge CLK) disable iff (!ARST_N)
		!s.present |=> (!IND.safety_out_a && !IND.safety_out_b && !IND.diag && !IND.yellow))
		else $error("outputs high with no actuator");
	a_resp_bits: assert property (@(posedge CLK) disable iff (!ARST_N)
		1'b1 |=> (RESP_BYTE[0] == $past(outs_on) && RESP_BYTE[3:2] == 2'b00))
		else $error("response byte wrong");
	a_fail_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
		(st_q == ST_FAIL && !frs && !s.internal) |=> st_q == ST_FAIL)
		else $error("failure left without reset");
endmodule : ssd_diag_status
`default_nettype wire

/* File: ssd_gw_model.sv */
// Fieldbus gateway as seen by one sensor: sends request bytes, collects status bytes.
// Assumes the sensor's clock and a chain holding this single sensor.
`timescale 1ns/10ps
`default_nettype none
module ssd_gw_model (
	// Clock and reset.
	input  wire logic       CLK,
	input  wire logic       ARST_N,
	// Link towards the sensor.
	input  wire logic [7:0] RESP_BYTE,
	input  wire logic [7:0] DIAG_BYTE,
	output var  logic [7:0] REQ_BYTE,
	output var  logic       REQ_STB,
	// Safety outputs towards the safety controller.
	input  wire logic       SAFE_A,
	input  wire logic       SAFE_B,
	output var  logic       CTL_RUN
);
	localparam int CHAIN_LEN = 1;
	logic [7:0] rx_resp_q;
	logic [7:0] rx_diag_q;
	initial begin
		REQ_BYTE = 8'h00;
		REQ_STB  = 1'b0;
	end
	// The sensor's status and diagnostic bytes are refreshed on every cycle.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rx_resp_q <= 8'h00;
			rx_diag_q <= 8'h00;
		end else begin
			rx_resp_q <= RESP_BYTE;
			rx_diag_q <= DIAG_BYTE;
		end
	end
	// Safety controller run flag; output dropouts up to DROP_CYCLES long are bridged.
	localparam int DROP_CYCLES = 4;
	logic [3:0] drop_q;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			drop_q  <= 4'h0;
			CTL_RUN <= 1'b0;
		end else if (SAFE_A && SAFE_B) begin
			drop_q  <= 4'h0;
			CTL_RUN <= 1'b1;
		end else if (drop_q < 4'(DROP_CYCLES)) begin
			drop_q  <= drop_q + 4'h1;
		end else begin
			CTL_RUN <= 1'b0;
		end
	end
	// One request byte per call; outside the strobe the byte is scrambled.
	task automatic send(input logic [7:0] b);
		@(posedge CLK);
		REQ_BYTE <= b;
		REQ_STB  <= 1'b1;
		@(posedge CLK);
		REQ_BYTE <= ~b;
		REQ_STB  <= 1'b0;
	endtask : send
endmodule : ssd_gw_model
`default_nettype wire

/* File: ssd_testbench.sv */
// Self-checking bench: indicators, status bytes, failure flow and registers.
// Assumes ssd_pkg, ssd_regs.svh and the gateway model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "ssd_regs.svh"
module testbench;
	import ssd_pkg::*;
	localparam int TK = 4;
	logic        clk;
	logic        arst_n;
	ssd_sense_t  sense;
	logic [7:0]  req_byte;
	logic        req_stb;
	ssd_ind_t    ind;
	logic [7:0]  resp;
	logic [7:0]  diag;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] rd;
	logic [1:0]  rs;
	int          err_count, checked;
	integer      nr, ny, nd, no;
	logic        ctl_run;

	ssd_diag_status #(.TICK_CYCLES(TK), .WARN_TICKS(3)) i_ssd_diag_status (
		.CLK(clk), .ARST_N(arst_n), .SENSE(sense), .REQ_BYTE(req_byte), .REQ_STB(req_stb),
		.IND(ind), .RESP_BYTE(resp), .DIAG_BYTE(diag),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	ssd_gw_model i_ssd_gw_model (.CLK(clk), .ARST_N(arst_n), .RESP_BYTE(resp),
		.DIAG_BYTE(diag), .REQ_BYTE(req_byte), .REQ_STB(req_stb),
		.SAFE_A(ind.safety_out_a), .SAFE_B(ind.safety_out_b), .CTL_RUN(ctl_run));

	always #4 clk = ~clk;

	task automatic end_of_test;
		if (err_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Green, yellow, diagnostic line and both safety outputs; red is checked on its own, directly or by counting.
	task automatic chk5(input logic [4:0] e);
		chk("ind", e, {ind.green, ind.yellow, ind.diag, ind.safety_out_a, ind.safety_out_b});
	endtask : chk5

	task automatic w8(input int n);
		repeat (n) @(posedge clk);
	endtask : w8

	task automatic win(input int n);
		nr = 0;
		ny = 0;
		nd = 0;
		no = 0;
		repeat (n) begin
			@(posedge clk);
			nr += ind.red;
			ny += ind.yellow;
			nd += ind.diag;
			no += ind.safety_out_a & ind.safety_out_b;
		end
	endtask : win

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : axr

	task automatic cause(input int n, input logic v);
		@(posedge clk);
		case (n)
			1: sense.flt_out_a <= v;
			2: sense.flt_out_b <= v;
			3: sense.cross_short <= v;
			4: sense.overtemp <= v;
			5: sense.act_err <= v;
			default: sense.internal <= v;
		endcase
		sense.comm_err <= v && n < 5;
	endtask : cause

	task automatic t_regs;
		axr(`SSD_CTRL_OFS);
		chk("ctrl", 32'h0, rd);
		chk("rresp", `SSD_RESP_OKAY, rs);
		axr(8'h0c);
		chk("rresp", `SSD_RESP_SLVERR, rs);
		chk("rdata", 32'h0, rd);
		axw(8'h0c, 32'hffff_ffff);
		chk("bresp", `SSD_RESP_SLVERR, rs);
		axw(`SSD_STAT_OFS, 32'h1);
		chk("bresp", `SSD_RESP_OKAY, rs);
	endtask : t_regs

	task automatic t_idle;
		chk5(5'b10000);
		chk("red", 1'b0, ind.red);
		chk("resp", 8'h00, resp);
	endtask : t_idle

	task automatic t_act;
		@(posedge clk);
		sense.present <= 1'b1;
		sense.safety_in_a <= 1'b1;
		sense.safety_in_b <= 1'b1;
		w8(6);
		chk5(5'b11111);
		chk("red", 1'b0, ind.red);
		chk("resp", 8'h13, resp);
		chk("diag", 8'h00, diag);
		chk("ctl", 1'b1, ctl_run);
		chk("gw_resp", 8'h13, i_ssd_gw_model.rx_resp_q);
	endtask : t_act

	task automatic t_limit;
		@(posedge clk);
		sense.limit <= 1'b1;
		w8(6);
		win(16);
		chk("yellow", 8, ny);
		chk("diagline", 8, nd);
		chk("outs", 16, no);
		chk("resp", 8'h33, resp);
		@(posedge clk);
		sense.limit <= 1'b0;
		w8(6);
	endtask : t_limit

	task automatic t_codes;
		for (int n = 1; n <= 5; n++) begin
			cause(n, 1'b1);
			if (n < 5) begin
				w8(6);
				chk5(5'b01011);
				chk("resp", 8'h53, resp);
				chk("diag", 8'h40 | (8'h01 << (n - 1)), diag);
				chk("ctl", 1'b1, ctl_run);
			end
			w8(30);
			chk5(5'b01000);
			chk("ctl", 1'b0, ctl_run);
			chk("resp", (n == 5) ? 8'h90 : 8'h92, resp);
			chk("diag", (n == 5) ? 8'h10 : 8'h01 << (n - 1), diag);
			win((2 * n + 4) * TK);
			chk("flashes", 4 * n, nr);
			if (n == 1) begin
				axr(`SSD_STAT_OFS);
				chk("status", 32'h0002_0192, rd);
			end
			cause(n, 1'b0);
			w8(6);
			chk("latched", 8'h92, resp);
			i_ssd_gw_model.send(8'h80);
			w8(4);
			chk("resp", 8'h13, resp);
			chk5(5'b11111);
		end
	endtask : t_codes

	task automatic t_internal;
		cause(6, 1'b1);
		w8(6);
		win(16);
		chk("red", 16, nr);
		chk("outs", 0, no);
		chk("resp", 8'h92, resp);
		chk("diag", 8'h20, diag);
		chk("gw_diag", 8'h20, i_ssd_gw_model.rx_diag_q);
		axr(`SSD_STAT_OFS);
		chk("status", 32'h0003_2092, rd);
		cause(6, 1'b0);
		w8(6);
		axw(`SSD_CTRL_OFS, 32'h2);
		w8(4);
		chk("resp", 8'h13, resp);
	endtask : t_internal

	task automatic t_serial;
		axw(`SSD_CTRL_OFS, 32'h1);
		axr(`SSD_CTRL_OFS);
		chk("ctrl", 32'h1, rd);
		w8(4);
		chk5(5'b11011);
		chk("resp", 8'h13, resp);
		i_ssd_gw_model.send(8'h5a);
		axr(`SSD_REQ_OFS);
		chk("req", 32'h5a, rd);
		axw(`SSD_REQ_OFS, 32'h0000_00a5);
		chk("bresp", `SSD_RESP_OKAY, rs);
		axr(`SSD_REQ_OFS);
		chk("req", 32'ha5, rd);
		axw(`SSD_CTRL_OFS, 32'h0);
	endtask : t_serial

	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		sense = '0;
		sense.supply_ok = 1'b1;
		sense.ready = 1'b1;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		err_count = 0;
		checked = 0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		w8(6);
		t_idle();
		t_regs();
		t_act();
		t_limit();
		t_codes();
		t_internal();
		t_serial();
		end_of_test();
	end

	// Whole run needs well under two thousand cycles.
	initial begin
		repeat (6000) @(posedge clk);
		err_count++;
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
